// >>> core/cmc_regs.vh
// Constants of the transceiver mode controller: clock, timing and flag widths.
// Assumes a single 25 MHz clock; times are in ns and converted to cycles in the core.
`ifndef CMC_REGS_VH
`define CMC_REGS_VH
`define CMC_CLK_NS 40
`define CMC_DEB_CYC 4
`define CMC_GTS_HOLD_NS 50000
`define CMC_DOM_MIN_NS 4000
`define CMC_EDGE_VALID 3'h4
`define CMC_FIFO_DEPTH 8
`define CMC_SYNC_W 11
`define CMC_SYNC_RST 11'h000
`define CMC_MODE_W 3
`endif

// >>> core/cmc_mode_ctrl.v
// Operating-mode controller of a CAN transceiver plus the receive bit FIFO.
// Assumes all pin inputs are asynchronous; undervoltage detectors and the
// wake-pattern detector are analog blocks reporting plain levels.
// Operation
// RULE_01: Both select pins high selects Normal mode.
// RULE_02: Standby-select high and mode-select low selects Listen-only mode.
// RULE_03: Both select pins low selects Standby mode.
// RULE_04: Transceiver or I/O supply undervoltage forces Sleep, overriding mode pins.
// RULE_05: Battery undervoltage forces Standby mode.
// RULE_06: Normal drives bus from transmit stream and returns bus state on receive.
// RULE_07: Listen-only keeps transmitter off, ignores transmit input, receiver still active.
// RULE_08: Normal disables wake-up detection, keeps local and bus failure diagnosis.
// RULE_09: Normal flag output shows wake-up source or bus-failure flag.
// RULE_10: Listen-only runs local diagnosis; flag output shows power-on or local-failure.
// RULE_11: Standby sets wake-up flag on bus wake pattern or local event.
// RULE_12: Standby shows wake-up flag on flag output and receive pin with supplies present.
// RULE_13: Standby turns transmitter and receiver off, wake-up detection on.
// RULE_14: Regulator control is active in Normal, Listen-only and Standby.
// RULE_15: Sleep deactivates regulator control, switching external regulators off.
// RULE_16: Go-to-Sleep held past the hold time enters Sleep.
// RULE_17: Rising standby-select edge with I/O supply leaves Sleep to Normal or Listen.
// RULE_18: Bus-failure flag valid after fourth long-enough dominant-to-recessive transmit edge.
// RULE_19: Mode pins are synchronised and debounced before decoding.
`timescale 1ns/1ns
`default_nettype none
`include "cmc_regs.vh"

module cmc_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = `CMC_FIFO_DEPTH,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk)
  begin
    if (clk_en && push)
      mem_q[wr_q] <= in_data;
  end
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else if (clk_en)
    begin
      // Pointers wrap only for power-of-two depths
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // cmc_fifo

module cmc_mode_ctrl #(
  parameter DEB_CYC = `CMC_DEB_CYC,
  parameter GTS_HOLD_CYC = (`CMC_GTS_HOLD_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS,
  parameter DOM_MIN_CYC = (`CMC_DOM_MIN_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  input wire clk_en,
  // Host mode pins
  input wire standby_select_n,
  input wire mode_select,
  // Host transmit stream, low is dominant
  input wire txd_n,
  // Analog receiver and wake-up detectors
  input wire bus_rx_n,
  input wire bus_wake_pattern,
  input wire local_wake,
  // Supply monitors, high means undervoltage
  input wire uv_cc,
  input wire uv_io,
  input wire uv_bat,
  // Diagnosis inputs, high means failure present
  input wire local_fail,
  input wire bus_fail,
  // Receive stream drain
  input wire rx_ready,
  output reg rx_valid_q,
  output reg rxd_q,
  output reg rx_overrun_q,
  // Bus driver and receiver controls
  output reg tx_dominant_q,
  output reg tx_enable_q,
  output reg rx_enable_q,
  output reg wake_detect_en_q,
  output reg diag_bus_en_q,
  // Host flags and regulator control
  output reg flag_output_n,
  output reg regulator_control_out,
  output reg [`CMC_MODE_W-1:0] mode_q
);
  localparam [2:0] ST_NORMAL = 3'h0;
  localparam [2:0] ST_LISTEN = 3'h1;
  localparam [2:0] ST_STANDBY = 3'h2;
  localparam [2:0] ST_GOSLEEP = 3'h3;
  localparam [2:0] ST_SLEEP = 3'h4;
  localparam [`CMC_SYNC_W-1:0] SYNC_RST = `CMC_SYNC_RST;

  wire [`CMC_SYNC_W-1:0] raw;
  reg [`CMC_SYNC_W-1:0] s1_q;
  reg [`CMC_SYNC_W-1:0] s2_q;
  assign raw = {standby_select_n, mode_select, txd_n, bus_rx_n, bus_wake_pattern,
    local_wake, uv_cc, uv_io, uv_bat, local_fail, bus_fail};

  // Two flops per pin; the first is read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < `CMC_SYNC_W; gi = gi + 1)
    begin : g_sync
      always @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          s1_q[gi] <= SYNC_RST[gi];
          s2_q[gi] <= SYNC_RST[gi];
        end
        else if (clk_en)
        begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  wire sel_n_s = s2_q[10];
  wire en_s = s2_q[9];
  wire txd_s = s2_q[8];
  wire rx_s = s2_q[7];
  wire wbus_s = s2_q[6];
  wire wloc_s = s2_q[5];
  wire uvcc_s = s2_q[4];
  wire uvio_s = s2_q[3];
  wire uvbat_s = s2_q[2];
  wire lfail_s = s2_q[1];
  wire bfail_s = s2_q[0];

  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [1:0] deb_q;
  reg [1:0] last_q;
  reg [15:0] deb_cnt_q;
  reg sel_prev_q;
  reg [15:0] gts_cnt_q;
  reg wbus_prev_q;
  reg wloc_prev_q;
  reg wake_q;
  reg wake_local_q;
  reg pwon_q;
  reg from_normal_q;
  reg [2:0] edge_q;
  reg [15:0] dom_cnt_q;
  reg txd_prev_q;

  wire wake_ev = (wbus_s && !wbus_prev_q) || (wloc_s && !wloc_prev_q);
  wire wake_act = (st_q == ST_STANDBY) || (st_q == ST_GOSLEEP) || (st_q == ST_SLEEP);
  wire sel_rise = deb_q[1] && !sel_prev_q;
  wire gts_done = (gts_cnt_q >= GTS_HOLD_CYC[15:0] - 16'h0001);
  wire fifo_ready;
  wire fifo_valid;
  wire fifo_data;

  always @*
  begin
    st_d = st_q;
    if (uvcc_s || uvio_s)
      st_d = ST_SLEEP; // see RULE_04
    else if (uvbat_s)
      st_d = ST_STANDBY; // see RULE_05
    else if (st_q == ST_SLEEP)
    begin
      if (sel_rise)
        st_d = deb_q[0] ? ST_NORMAL : ST_LISTEN; // see RULE_17
      else if (wake_q)
        st_d = ST_STANDBY;
    end
    else
    begin
      case (deb_q)
        2'h3: st_d = ST_NORMAL; // see RULE_01
        2'h2: st_d = ST_LISTEN; // see RULE_02
        2'h0: st_d = ST_STANDBY; // see RULE_03
        default:
        begin
          // A wake-up during Go-to-Sleep overrules the command
          if (st_q == ST_GOSLEEP && gts_done && !wake_q && !wake_ev)
            st_d = ST_SLEEP; // see RULE_16
          else
            st_d = ST_GOSLEEP;
        end
      endcase
    end
  end

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= ST_STANDBY;
      deb_q <= 2'h0;
      last_q <= 2'h0;
      deb_cnt_q <= 16'h0000;
      sel_prev_q <= 1'b0;
      gts_cnt_q <= 16'h0000;
      wbus_prev_q <= 1'b0;
      wloc_prev_q <= 1'b0;
      wake_q <= 1'b0;
      wake_local_q <= 1'b0;
      pwon_q <= 1'b1;
      from_normal_q <= 1'b0;
      edge_q <= 3'h0;
      dom_cnt_q <= 16'h0000;
      txd_prev_q <= 1'b1;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
      // A level must hold DEB_CYC + 1 cycles before it is decoded
      last_q <= {sel_n_s, en_s};
      if ({sel_n_s, en_s} != last_q)
        deb_cnt_q <= 16'h0000; // see RULE_19
      else if (deb_cnt_q >= DEB_CYC[15:0] - 16'h0001)
        deb_q <= last_q; // see RULE_19
      else
        deb_cnt_q <= deb_cnt_q + 16'h0001;
      sel_prev_q <= deb_q[1];
      if (st_q == ST_GOSLEEP && st_d == ST_GOSLEEP)
        gts_cnt_q <= gts_cnt_q + 16'h0001; // see RULE_16
      else
        gts_cnt_q <= 16'h0000;
      wbus_prev_q <= wbus_s;
      wloc_prev_q <= wloc_s;
      // Set wins over the clear made on entering Normal
      if (wake_act && wake_ev)
      begin
        wake_q <= 1'b1; // see RULE_11
        wake_local_q <= wloc_s && !wloc_prev_q;
      end
      else if (st_d == ST_NORMAL && st_q != ST_NORMAL)
        wake_q <= 1'b0;
      if (st_d == ST_NORMAL)
        pwon_q <= 1'b0;
      if (st_d == ST_LISTEN && st_q != ST_LISTEN)
        from_normal_q <= (st_q == ST_NORMAL); // see RULE_10
      // Only dominant phases of the minimum length count as edges
      txd_prev_q <= txd_s;
      if (st_q != ST_NORMAL)
      begin
        edge_q <= 3'h0;
        dom_cnt_q <= 16'h0000;
      end
      else if (!txd_s)
      begin
        if (dom_cnt_q != 16'hFFFF)
          dom_cnt_q <= dom_cnt_q + 16'h0001;
      end
      else
      begin
        dom_cnt_q <= 16'h0000;
        if (!txd_prev_q && dom_cnt_q >= DOM_MIN_CYC[15:0] && edge_q != `CMC_EDGE_VALID)
          edge_q <= edge_q + 3'h1; // see RULE_18
      end
    end
  end

  cmc_fifo #(
    .WIDTH(1),
    .DEPTH(`CMC_FIFO_DEPTH),
    .AW(3)
  ) u_rx_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(rx_enable_q),
    .in_ready(fifo_ready),
    .in_data(rx_s),
    .out_valid(fifo_valid),
    .out_ready(rx_ready && rx_enable_q),
    .out_data(fifo_data)
  );

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_valid_q <= 1'b0;
      rxd_q <= 1'b1;
      rx_overrun_q <= 1'b0;
      tx_dominant_q <= 1'b0;
      tx_enable_q <= 1'b0;
      rx_enable_q <= 1'b0;
      wake_detect_en_q <= 1'b1;
      diag_bus_en_q <= 1'b0;
      flag_output_n <= 1'b1;
      regulator_control_out <= 1'b1;
      mode_q <= ST_STANDBY;
    end
    else if (clk_en)
    begin
      mode_q <= st_q;
      // Transmit input is ignored outside Normal
      tx_enable_q <= (st_q == ST_NORMAL); // see RULE_06 RULE_07 RULE_13
      tx_dominant_q <= (st_q == ST_NORMAL) && !txd_s; // see RULE_06 RULE_07
      rx_enable_q <= (st_q == ST_NORMAL) || (st_q == ST_LISTEN); // see RULE_07 RULE_13
      wake_detect_en_q <= wake_act; // see RULE_08 RULE_13
      diag_bus_en_q <= (st_q == ST_NORMAL); // see RULE_08 RULE_10
      regulator_control_out <= (st_q != ST_SLEEP); // see RULE_14 RULE_15
      // Overrun is sticky until the receiver is switched off; bits are dropped when full
      if (!rx_enable_q)
        rx_overrun_q <= 1'b0;
      else if (!fifo_ready)
        rx_overrun_q <= 1'b1;
      if (rx_enable_q)
      begin
        rx_valid_q <= fifo_valid && rx_ready;
        if (fifo_valid && rx_ready)
          rxd_q <= fifo_data; // see RULE_06
      end
      else
      begin
        rx_valid_q <= 1'b0;
        rxd_q <= !(wake_q && !uvio_s && !uvbat_s); // see RULE_12
      end
      case (st_q)
        ST_NORMAL:
          flag_output_n <= (edge_q == `CMC_EDGE_VALID) ? !bfail_s : !wake_local_q; // see RULE_09 RULE_18
        ST_LISTEN:
          flag_output_n <= from_normal_q ? !lfail_s : !pwon_q; // see RULE_10
        default:
          flag_output_n <= !(wake_q && !uvio_s && !uvbat_s); // see RULE_12
      endcase
    end
  end
endmodule // cmc_mode_ctrl
`default_nettype wire

// >>> tb/cmc_mode_ctrl_assertions.sv
// Checker of the mode controller: enables, regulator and flags per mode.
// Assumes binding to cmc_mode_ctrl, mode codes 0..4 Normal..Sleep.
`timescale 1ns/1ns
`default_nettype none
module cmc_mode_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Supplies
  input wire logic uv_cc,
  input wire logic uv_io,
  input wire logic uv_bat,
  // Watched outputs
  input wire logic rxd_q,
  input wire logic tx_dominant_q,
  input wire logic tx_enable_q,
  input wire logic rx_enable_q,
  input wire logic wake_detect_en_q,
  input wire logic diag_bus_en_q,
  input wire logic flag_output_n,
  input wire logic regulator_control_out,
  input wire logic [2:0] mode_q
);
  wire any_uv = uv_cc || uv_io;
  wire bat_uv = uv_bat && !any_uv;
  wire sup_ok = !uv_io && !uv_bat;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Twelve cycles cover sync flops and state update
  uv_sleep_a: assert property (any_uv[*8] ##1 any_uv[*4] |-> mode_q == 3'h4)
    else $error("sleep not forced");
  bat_stby_a: assert property (bat_uv[*8] ##1 bat_uv[*4] |-> mode_q == 3'h2)
    else $error("standby not forced");
  reg_on_a: assert property (mode_q != 3'h4 && $past(mode_q) != 3'h4 |-> regulator_control_out)
    else $error("regulator off");
  reg_off_a: assert property (mode_q == 3'h4 && $past(mode_q) == 3'h4 |-> !regulator_control_out)
    else $error("regulator on in sleep");
  tx_mode_a: assert property (tx_dominant_q |-> mode_q == 3'h0)
    else $error("drive outside normal");
  tx_en_a: assert property (tx_enable_q == (mode_q == 3'h0))
    else $error("transmit enable");
  rx_en_a: assert property (rx_enable_q == (mode_q <= 3'h1))
    else $error("receive enable");
  wake_en_a: assert property (mode_q inside {3'h0, 3'h2} |-> wake_detect_en_q == mode_q[1])
    else $error("wake detect enable");
  diag_on_a: assert property (mode_q == 3'h0 |-> diag_bus_en_q)
    else $error("bus diagnosis off");
  stby_flag_a: assert property (sup_ok[*4] ##0 mode_q == 3'h2 && $past(mode_q) == 3'h2 |-> rxd_q == flag_output_n)
    else $error("wake flag pins differ");
  cover property (mode_q == 3'h1);
  cover property (mode_q == 3'h4);
  cover property (tx_dominant_q);
endmodule // cmc_mode_checker
bind cmc_mode_ctrl cmc_mode_checker i_cmc_mode_checker (
  .clk(clk),
  .reset_n(reset_n),
  .uv_cc(uv_cc),
  .uv_io(uv_io),
  .uv_bat(uv_bat),
  .rxd_q(rxd_q),
  .tx_dominant_q(tx_dominant_q),
  .tx_enable_q(tx_enable_q),
  .rx_enable_q(rx_enable_q),
  .wake_detect_en_q(wake_detect_en_q),
  .diag_bus_en_q(diag_bus_en_q),
  .flag_output_n(flag_output_n),
  .regulator_control_out(regulator_control_out),
  .mode_q(mode_q)
);
`default_nettype wire

// >>> tb/cmc_host_model.sv
// Host model: mode pins, transmit bit stream and receive drain ready.
// Assumes bench commands change just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
module cmc_host_model #(
  parameter int DOM = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bench commands
  input wire logic [1:0] pins,
  input wire logic tx_go,
  input wire logic stall,
  // Pins to the controller
  output logic standby_select_n,
  output logic mode_select,
  output logic txd_n,
  output logic rx_ready
);
  logic [7:0] cnt_q;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {standby_select_n, mode_select} <= 2'h0;
      txd_n <= 1'b1;
      rx_ready <= 1'b0;
      cnt_q <= 8'h00;
    end
    else
    begin
      {standby_select_n, mode_select} <= pins;
      rx_ready <= !stall;
      // Dominant half is DOM long; the bench's DOM of 8 is above its DOM_MIN_CYC of 4 that the flag needs
      cnt_q <= (tx_go && cnt_q < 2 * DOM - 1) ? cnt_q + 8'h01 : 8'h00;
      txd_n <= !(tx_go && cnt_q < DOM);
    end
  end
endmodule // cmc_host_model
`default_nettype wire

// >>> tb/cmc_mode_ctrl_tb.sv
// Bench of the mode controller: supplies, wake and bus bits driven here.
// Assumes the host model drives mode pins, transmit stream and drain.
`timescale 1ns/1ns
`default_nettype none
module cmc_mode_ctrl_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] pins = 2'h0;
  logic tx_go = 1'b0, stall = 1'b0, bus_rx_n = 1'b1, bus_wake_pattern = 1'b0;
  logic local_wake = 1'b0, uv_cc = 1'b0, uv_io = 1'b0, uv_bat = 1'b0;
  logic local_fail = 1'b0, bus_fail = 1'b0;
  logic clk_en = 1'b1;
  int failures = 0;
  int num_checks = 0;
  wire standby_select_n, mode_select, txd_n, rx_ready, rx_valid_q, rxd_q, rx_overrun_q;
  wire tx_dominant_q, tx_enable_q, rx_enable_q, wake_detect_en_q, diag_bus_en_q;
  wire flag_output_n, regulator_control_out;
  wire [2:0] mode_q;
  always #20 clk = ~clk;
  // Short hold and dominant counts keep the run brief
  cmc_mode_ctrl #(.GTS_HOLD_CYC(8), .DOM_MIN_CYC(4)) i_cmc_mode_ctrl (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .standby_select_n(standby_select_n), .mode_select(mode_select), .txd_n(txd_n),
    .bus_rx_n(bus_rx_n), .bus_wake_pattern(bus_wake_pattern), .local_wake(local_wake),
    .uv_cc(uv_cc), .uv_io(uv_io), .uv_bat(uv_bat),
    .local_fail(local_fail), .bus_fail(bus_fail),
    .rx_ready(rx_ready), .rx_valid_q(rx_valid_q), .rxd_q(rxd_q), .rx_overrun_q(rx_overrun_q),
    .tx_dominant_q(tx_dominant_q), .tx_enable_q(tx_enable_q), .rx_enable_q(rx_enable_q),
    .wake_detect_en_q(wake_detect_en_q), .diag_bus_en_q(diag_bus_en_q),
    .flag_output_n(flag_output_n), .regulator_control_out(regulator_control_out),
    .mode_q(mode_q)
  );
  cmc_host_model #(.DOM(8)) i_cmc_host_model (
    .clk(clk), .reset_n(reset_n), .pins(pins), .tx_go(tx_go), .stall(stall),
    .standby_select_n(standby_select_n), .mode_select(mode_select), .txd_n(txd_n),
    .rx_ready(rx_ready)
  );
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Sample at the falling edge, away from the design's updates
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic go(input logic [1:0] p);
    @(posedge clk);
    pins <= p;
    cyc(30);
  endtask
  task automatic t_mode(input logic [1:0] p, input logic [2:0] m);
    go(p);
    chk({1'b0, mode_q}, {1'b0, m});
    chk({2'h0, tx_enable_q, rx_enable_q}, {2'h0, m == 3'h0, m < 3'h2});
    chk({2'h0, wake_detect_en_q, regulator_control_out}, {2'h0, m == 3'h2, 1'b1});
  endtask
  task automatic dom_count(input int n, output int d);
    d = 0;
    repeat (n)
    begin
      @(negedge clk);
      d += tx_dominant_q;
    end
  endtask
  task automatic t_tx;
    int dom;
    go(2'h3);
    @(posedge clk);
    bus_fail <= 1'b1;
    tx_go <= 1'b1;
    dom_count(100, dom);
    chk({3'h0, dom > 20}, 4'h1);
    chk({3'h0, flag_output_n}, 4'h0);
    go(2'h2);
    dom_count(40, dom);
    chk({3'h0, dom == 0}, 4'h1);
    @(posedge clk);
    tx_go <= 1'b0;
  endtask
  task automatic t_rx;
    @(posedge clk);
    stall <= 1'b1;
    cyc(20);
    chk({3'h0, rx_overrun_q}, 4'h1);
    @(posedge clk);
    stall <= 1'b0;
    bus_rx_n <= 1'b0;
    cyc(20);
    chk({2'h0, rx_valid_q, rxd_q}, 4'h2);
    @(posedge clk);
    bus_rx_n <= 1'b1;
  endtask
  task automatic t_wake;
    for (int i = 0; i < 2; i++)
    begin
      go(2'h3);
      chk({3'h0, flag_output_n}, {3'h0, i == 0});
      go(2'h0);
      chk({2'h0, flag_output_n, rxd_q}, 4'h3);
      @(posedge clk);
      {bus_wake_pattern, local_wake} <= 2'h1 << i;
      cyc(10);
      chk({2'h0, flag_output_n, rxd_q}, 4'h0);
      @(posedge clk);
      {bus_wake_pattern, local_wake} <= 2'h0;
    end
  endtask
  task automatic t_sleep;
    go(2'h3);
    go(2'h1);
    chk({regulator_control_out, mode_q}, 4'h4);
    go(2'h3);
    chk({regulator_control_out, mode_q}, 4'h8);
    // A wake in Sleep brings the regulator back; the held command then stalls in Go-to-Sleep
    go(2'h1);
    @(posedge clk);
    local_wake <= 1'b1;
    cyc(10);
    chk({regulator_control_out, mode_q}, 4'hB);
    @(posedge clk);
    local_wake <= 1'b0;
    go(2'h3);
  endtask
  task automatic t_freeze;
    @(posedge clk);
    clk_en <= 1'b0;
    go(2'h2);
    chk({1'b0, mode_q}, 4'h0);
    @(posedge clk);
    clk_en <= 1'b1;
    cyc(30);
    chk({1'b0, mode_q}, 4'h1);
  endtask
  task automatic t_uv;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      {uv_bat, uv_io, uv_cc} <= 3'h1 << i;
      cyc(30);
      chk({regulator_control_out, mode_q}, (i == 2) ? 4'hA : 4'h4);
      @(posedge clk);
      {uv_bat, uv_io, uv_cc} <= 3'h0;
      go(2'h0);
      go(2'h3);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    cyc(2);
    chk({flag_output_n, rxd_q, regulator_control_out, 1'b0}, 4'hE);
    t_mode(2'h3, 3'h0);
    @(posedge clk);
    local_fail <= 1'b1;
    t_mode(2'h2, 3'h1);
    chk({3'h0, flag_output_n}, 4'h0);
    t_mode(2'h0, 3'h2);
    t_tx;
    t_rx;
    t_wake;
    t_sleep;
    t_uv;
    t_freeze;
    wrap_up;
  end
  // The run needs about 1000 cycles; six times that means a hang
  initial
  begin
    repeat (6000) @(posedge clk);
    failures++;
    wrap_up;
  end
endmodule // cmc_mode_ctrl_tb
`default_nettype wire
